// *** rtl/pmp_pager.v ***
// panel monitor pager: keys, mode and item selection, pulse counter, paged decimal display
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "pmp_regs.vh"
module pmp_pager
#(
    parameter DEB_CYC = (`PMP_CLK_HZ / 1000) * `PMP_DEB_MS,
    parameter LONG_CYC = (`PMP_CLK_HZ / 1000) * `PMP_LONG_MS
)
(
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // panel keys, high while pressed
    input wire key_mode_i,
    input wire key_up_i,
    input wire key_down_i,
    input wire key_page_i,
    // monitored signals
    input wire pulse_inc_i,
    input wire pulse_dec_i,
    input wire hall_u_i,
    input wire hall_v_i,
    input wire hall_w_i,
    input wire [7:0] in_term_i,
    // display
    output reg [39:0] disp_char_o,
    output wire [1:0] panel_mode_o
);
    // debounce all four keys; a key must sit still for DEB_CYC before it counts
    wire [3:0] key_raw = {key_page_i, key_down_i, key_up_i, key_mode_i};
    wire [3:0] key_lvl;
    reg [3:0] key_prev_q;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_key
            reg [31:0] cnt_q;
            reg lvl_q;
            always @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    cnt_q <= 32'h00000000;
                    lvl_q <= 1'b0;
                end
                else if (key_raw[g] == lvl_q)
                    cnt_q <= 32'h00000000;
                else if (cnt_q >= DEB_CYC - 1)
                begin
                    lvl_q <= key_raw[g];
                    cnt_q <= 32'h00000000;
                end
                else
                    cnt_q <= cnt_q + 32'h00000001;
            end
            assign key_lvl[g] = lvl_q;
        end
    endgenerate

    wire [3:0] key_rise = key_lvl & ~key_prev_q;
    wire mode_ev = key_rise[0];
    wire up_ev = key_rise[1];
    wire down_ev = key_rise[2];

    // page key: long event fires once while held, short event on release of a brief press
    reg [31:0] hold_q;
    reg long_done_q;
    wire page_long = key_lvl[3] & ~long_done_q & (hold_q >= LONG_CYC - 1);
    wire page_short = ~key_lvl[3] & key_prev_q[3] & ~long_done_q;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            key_prev_q <= 4'h0;
            hold_q <= 32'h00000000;
            long_done_q <= 1'b0;
        end
        else
        begin
            key_prev_q <= key_lvl;
            if (!key_lvl[3])
            begin
                hold_q <= 32'h00000000;
                long_done_q <= 1'b0;
            end
            else if (page_long)
                long_done_q <= 1'b1;
            else if (!long_done_q)
                hold_q <= hold_q + 32'h00000001;
        end
    end

    // registers
    reg ctrl_lvs_q;
    reg [31:0] res_lim_q;
    reg [31:0] spd_lim_q;
    reg [31:0] count_q;
    reg [1:0] mode_q;
    reg [1:0] item_q;
    reg [1:0] page_q;
    reg view_q;

    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr = wb_req & wb_we_i;
    integer b;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_lvs_q <= `PMP_CTRL_RST;
            res_lim_q <= `PMP_RES_LIMIT_RST;
            spd_lim_q <= `PMP_SPD_LIMIT_RST;
        end
        else if (wb_wr)
        begin
            if (wb_adr_i == `PMP_OFS_CTRL && wb_sel_i[0])
                ctrl_lvs_q <= wb_dat_i[`PMP_CTRL_LVS_BIT];
            for (b = 0; b < 4; b = b + 1)
            begin
                if (wb_sel_i[b] && wb_adr_i == `PMP_OFS_RES_LIMIT)
                    res_lim_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                if (wb_sel_i[b] && wb_adr_i == `PMP_OFS_SPD_LIMIT)
                    spd_lim_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
        end
    end

    reg [31:0] rd_d;
    always @*
    begin
        rd_d = 32'h00000000;
        case (wb_adr_i)
            `PMP_OFS_CTRL: rd_d[`PMP_CTRL_LVS_BIT] = ctrl_lvs_q;
            `PMP_OFS_RES_LIMIT: rd_d = res_lim_q;
            `PMP_OFS_SPD_LIMIT: rd_d = spd_lim_q;
            `PMP_OFS_STATUS:
            begin
                rd_d[`PMP_ST_MODE_LSB +: 2] = mode_q;
                rd_d[`PMP_ST_ITEM_LSB +: 2] = item_q;
                rd_d[`PMP_ST_PAGE_LSB +: 2] = page_q;
                rd_d[`PMP_ST_VIEW_BIT] = view_q;
            end
            `PMP_OFS_COUNT: rd_d = count_q;
            default: rd_d = 32'h00000000;
        endcase
    end

    // one wait state; unmapped offsets still ack and read zero so the bus never hangs
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            if (wb_req)
                wb_dat_o <= rd_d;
        end
    end

    // pulse counter: plain two's complement arithmetic gives the wrap at both limits
    always @(posedge clk_i)
    begin
        if (rst_i)
            count_q <= 32'h00000000;
        else if (pulse_inc_i && !pulse_dec_i)
            count_q <= count_q + 32'h00000001;
        else if (pulse_dec_i && !pulse_inc_i)
            count_q <= count_q - 32'h00000001;
    end

    // panel mode and monitor navigation
    wire paged_item = (item_q == `PMP_IT_PULSE) || (item_q == `PMP_IT_LIMIT);
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_q <= `PMP_MODE_STATUS;
            item_q <= `PMP_IT_INPUT;
            page_q <= `PMP_PG_LOW;
            view_q <= 1'b0;
        end
        else if (mode_ev)
        begin
            mode_q <= mode_q + 2'h1;
            view_q <= 1'b0;
            page_q <= `PMP_PG_LOW;
        end
        else if (mode_q == `PMP_MODE_MON)
        begin
            if (!view_q)
            begin
                if (up_ev)
                    item_q <= item_q + 2'h1;
                else if (down_ev)
                    item_q <= item_q - 2'h1;
                else if (page_long)
                begin
                    view_q <= 1'b1;
                    page_q <= `PMP_PG_LOW;
                end
            end
            else if (page_long)
                view_q <= 1'b0;
            else if (page_short && paged_item)
            begin
                case (page_q)
                    `PMP_PG_LOW: page_q <= `PMP_PG_MID;
                    `PMP_PG_MID: page_q <= `PMP_PG_TOP;
                    default: page_q <= `PMP_PG_LOW;
                endcase
            end
        end
    end

    assign panel_mode_o = mode_q;
    // value feeding the decimal converter, refreshed continuously
    reg [31:0] val;
    always @*
    begin
        if (item_q == `PMP_IT_PULSE)
            val = count_q;
        else if (ctrl_lvs_q)
            val = spd_lim_q;
        else
            val = res_lim_q;
    end

    wire conv_busy;
    wire conv_start = ~conv_busy;
    wire [39:0] bcd;
    reg neg_cap_q;
    reg neg_q;
    reg [39:0] bcd_q;
    wire [31:0] mag = val[31] ? (32'h00000000 - val) : val;
    // sign and digits move together at the next start edge, so a sign change never sits beside stale digits
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            neg_cap_q <= 1'b0;
            neg_q <= 1'b0;
            bcd_q <= 40'h0000000000;
        end
        else if (conv_start)
        begin
            neg_cap_q <= val[31];
            neg_q <= neg_cap_q;
            bcd_q <= bcd;
        end
    end

    pmp_bin2bcd u_conv
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(conv_start),
        .bin_i(mag),
        .busy_o(conv_busy),
        .bcd_o(bcd)
    );

    // display composition; position 0 is the rightmost character
    reg [39:0] disp_d;
    reg [11:0] item_id;
    integer i;
    always @*
    begin
        disp_d = {8{`PMP_CH_BLANK}};
        case (item_q)
            `PMP_IT_INPUT: item_id = `PMP_ID_INPUT;
            `PMP_IT_PULSE: item_id = `PMP_ID_PULSE;
            `PMP_IT_LIMIT: item_id = `PMP_ID_LIMIT;
            default: item_id = `PMP_ID_HALL;
        endcase
        if (mode_q != `PMP_MODE_MON)
        begin
            disp_d[9:5] = `PMP_CH_MINUS;
            disp_d[4:0] = {3'h0, mode_q};
        end
        else if (!view_q)
        begin
            disp_d[24:20] = `PMP_CH_U;
            disp_d[19:15] = `PMP_CH_N;
            disp_d[14:10] = {1'b0, item_id[11:8]};
            disp_d[9:5] = {1'b0, item_id[7:4]};
            disp_d[4:0] = {1'b0, item_id[3:0]};
        end
        else if (item_q == `PMP_IT_INPUT)
        begin
            for (i = 0; i < 8; i = i + 1)
                disp_d[i*5 +: 5] = in_term_i[i] ? `PMP_CH_BOTSEG : `PMP_CH_TOPSEG;
        end
        else if (item_q == `PMP_IT_HALL)
        begin
            disp_d[4:0] = hall_u_i ? `PMP_CH_TOPSEG : `PMP_CH_BOTSEG;
            disp_d[9:5] = hall_v_i ? `PMP_CH_TOPSEG : `PMP_CH_BOTSEG;
            disp_d[14:10] = hall_w_i ? `PMP_CH_TOPSEG : `PMP_CH_BOTSEG;
        end
        else
        begin
            disp_d[24:20] = neg_q ? `PMP_CH_MINUS : `PMP_CH_BLANK;
            case (page_q)
                `PMP_PG_LOW:
                    for (i = 0; i < 4; i = i + 1)
                        disp_d[i*5 +: 5] = {1'b0, bcd_q[i*4 +: 4]};
                `PMP_PG_MID:
                    for (i = 0; i < 4; i = i + 1)
                        disp_d[i*5 +: 5] = {1'b0, bcd_q[16 + i*4 +: 4]};
                default:
                    for (i = 0; i < 2; i = i + 1)
                        disp_d[i*5 +: 5] = {1'b0, bcd_q[32 + i*4 +: 4]};
            endcase
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
            disp_char_o <= {8{`PMP_CH_BLANK}};
        else
            disp_char_o <= disp_d;
    end
endmodule
`default_nettype wire

// *** rtl/pmp_regs.vh ***
// register offsets, fields, reset values, codes and timing figures for the panel monitor pager
`ifndef PMP_REGS_VH
`define PMP_REGS_VH

// register byte offsets
`define PMP_OFS_CTRL 8'h00
`define PMP_OFS_RES_LIMIT 8'h04
`define PMP_OFS_SPD_LIMIT 8'h08
`define PMP_OFS_STATUS 8'h0C
`define PMP_OFS_COUNT 8'h10

// fields
`define PMP_CTRL_LVS_BIT 0
`define PMP_ST_MODE_LSB 0
`define PMP_ST_ITEM_LSB 2
`define PMP_ST_PAGE_LSB 4
`define PMP_ST_VIEW_BIT 6

// reset values
`define PMP_CTRL_RST 1'h0
`define PMP_RES_LIMIT_RST 32'h00000000
`define PMP_SPD_LIMIT_RST 32'h00000000

// timing
`define PMP_CLK_HZ 100000000
`define PMP_LONG_MS 1000
`define PMP_DEB_MS 10

// panel modes
`define PMP_MODE_STATUS 2'h0
`define PMP_MODE_UTIL 2'h1
`define PMP_MODE_PARAM 2'h2
`define PMP_MODE_MON 2'h3

// monitor items, by index, and their identifiers
`define PMP_IT_INPUT 2'h0
`define PMP_IT_PULSE 2'h1
`define PMP_IT_LIMIT 2'h2
`define PMP_IT_HALL 2'h3
`define PMP_ID_INPUT 12'h005
`define PMP_ID_PULSE 12'h00D
`define PMP_ID_LIMIT 12'h010
`define PMP_ID_HALL 12'h011

// value pages
`define PMP_PG_LOW 2'h0
`define PMP_PG_MID 2'h1
`define PMP_PG_TOP 2'h2

// display character codes (0..15 are hex digits)
`define PMP_CH_U 5'h10
`define PMP_CH_N 5'h11
`define PMP_CH_MINUS 5'h12
`define PMP_CH_BLANK 5'h13
`define PMP_CH_TOPSEG 5'h14
`define PMP_CH_BOTSEG 5'h15

`endif

// *** rtl/pmp_bin2bcd.v ***
// sequential binary to ten-digit decimal converter
`timescale 1ns/100ps
`default_nettype none
module pmp_bin2bcd
(
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // request
    input wire start_i,
    input wire [31:0] bin_i,
    // result
    output wire busy_o,
    output reg [39:0] bcd_o
);
    reg [31:0] sh_q;
    reg [39:0] work_q;
    reg [5:0] cnt_q;
    reg busy_q;
    wire [39:0] adj;

    // add-three correction per decimal digit before each shift
    genvar d;
    generate
        for (d = 0; d < 10; d = d + 1)
        begin : g_dig
            assign adj[d*4 +: 4] = (work_q[d*4 +: 4] >= 4'h5) ? (work_q[d*4 +: 4] + 4'h3) : work_q[d*4 +: 4];
        end
    endgenerate

    assign busy_o = busy_q;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sh_q <= 32'h00000000;
            work_q <= 40'h0000000000;
            cnt_q <= 6'h00;
            busy_q <= 1'b0;
            bcd_o <= 40'h0000000000;
        end
        else if (!busy_q)
        begin
            if (start_i)
            begin
                sh_q <= bin_i;
                work_q <= 40'h0000000000;
                cnt_q <= 6'h00;
                busy_q <= 1'b1;
            end
        end
        else
        begin
            work_q <= {adj[38:0], sh_q[31]};
            sh_q <= {sh_q[30:0], 1'b0};
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == 6'h1F)
            begin
                busy_q <= 1'b0;
                bcd_o <= {adj[38:0], sh_q[31]};
            end
        end
    end
endmodule
`default_nettype wire

// *** verification/pmp_pager_sva.sv ***
// port checker for the panel monitor pager, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module pmp_pager_sva
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // panel
    input wire logic [39:0] disp_char_o,
    input wire logic [1:0] panel_mode_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    unmapped_zero_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) > 8'h10 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    ctrl_width_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 8'h00 |-> wb_dat_o[31:1] == 31'h0)
        else $error("control read has stray bits");
    mode_step_a: assert property (panel_mode_o != $past(panel_mode_o) |-> panel_mode_o == $past(panel_mode_o) + 2'h1)
        else $error("panel mode skipped a step");
    reset_blank_a: assert property (disable iff (1'b0) rst_i |=> disp_char_o == {8{5'h13}} && panel_mode_o == 2'h0)
        else $error("reset state wrong");
    // display lags the mode by one cycle, so both samples must be mode 0
    mode0_screen_a: assert property (panel_mode_o == 2'h0 && $past(panel_mode_o) == 2'h0 && !$past(rst_i)
        |-> disp_char_o[9:0] == {5'h12, 5'h00})
        else $error("status screen wrong");
endmodule
bind pmp_pager pmp_pager_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .disp_char_o(disp_char_o), .panel_mode_o(panel_mode_o));
`default_nettype wire

// *** verification/pmp_operator.sv ***
// operator model pressing the panel keys for short or long holds
`timescale 1ns/100ps
`default_nettype none
module pmp_operator
(
    // clock
    input wire logic clk_i,
    // keys: mode, up, down, page
    output logic [3:0] keys_o
);
    initial keys_o = 4'h0;
    // short stays under the hold threshold after debounce, long clears it by a margin
    task automatic press(input int k, input logic lng);
        begin
            @(posedge clk_i);
            keys_o[k] <= 1'b1;
            repeat (lng ? 40 : 10) @(posedge clk_i);
            keys_o[k] <= 1'b0;
            repeat (12) @(posedge clk_i);
        end
    endtask
endmodule
`default_nettype wire

// *** verification/pmp_pager_test.sv ***
// self-checking bench for the panel monitor pager
`timescale 1ns/100ps
`default_nettype none
module pmp_pager_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic pulse_inc_i = 1'b0, pulse_dec_i = 1'b0;
    logic hall_u_i = 1'b0, hall_v_i = 1'b0, hall_w_i = 1'b0;
    logic [7:0] in_term_i = 8'h00;
    wire [31:0] wb_dat_o;
    wire wb_ack_o;
    wire [39:0] disp_char_o;
    wire [1:0] panel_mode_o;
    wire [3:0] keys;
    int num_errors = 0;
    int n_compared = 0;
    logic [31:0] rd;

    always #5 clk_i = ~clk_i;

    pmp_operator u_pmp_operator (.clk_i(clk_i), .keys_o(keys));
    pmp_pager #(.DEB_CYC(4), .LONG_CYC(20)) u_pmp_pager (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .key_mode_i(keys[0]), .key_up_i(keys[1]), .key_down_i(keys[2]), .key_page_i(keys[3]),
        .pulse_inc_i(pulse_inc_i), .pulse_dec_i(pulse_dec_i), .hall_u_i(hall_u_i),
        .hall_v_i(hall_v_i), .hall_w_i(hall_w_i), .in_term_i(in_term_i),
        .disp_char_o(disp_char_o), .panel_mode_o(panel_mode_o));

    task tally_and_finish;
        begin
            $display("compared %0d, mismatched %0d", n_compared, num_errors);
            if (num_errors == 0 && n_compared > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    task chk(input string what, input logic [31:0 ] exp, input logic [31:0] got);
        begin
            n_compared++;
            if (got !== exp)
            begin
                num_errors++;
                $display("[ERR] %s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    // classic cycle: hold until ack is sampled high, take data at that edge
    task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        begin
            n = 0;
            @(posedge clk_i);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= we;
            wb_adr_i <= adr;
            wb_dat_i <= dat;
            @(posedge clk_i);
            while (wb_ack_o !== 1'b1 && n < 50)
            begin
                @(posedge clk_i);
                n++;
            end
            chk("bus ack", 32'h1, {31'h0, wb_ack_o});
            rd = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
        end
    endtask

    task rchk(input string what, input logic [7:0] adr, input logic [31:0] exp);
        begin
            wb(1'b0, adr, 32'h0);
            chk(what, exp, rd);
        end
    endtask

    task pos(input int p, input logic [4:0] exp);
        begin
            chk("display char", {27'h0, exp}, {27'h0, disp_char_o[p*5+:5]});
        end
    endtask

    task key(input int k, input logic lng, input logic [6:0] st);
        begin
            u_pmp_operator.press(k, lng);
            rchk("status", 8'h0C, {25'h0, st});
            repeat (70) @(posedge clk_i);
        end
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_i);
        chk("watchdog", 32'h0, 32'h1);
        tally_and_finish;
    end

    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk("ctrl", 8'h00, 32'h0);
        rchk("res limit", 8'h04, 32'h0);
        rchk("spd limit", 8'h08, 32'h0);
        wb(1'b1, 8'h20, 32'hFFFFFFFF);
        rchk("unmapped", 8'h20, 32'h0);
        $display("test registers done");
        for (int i = 1; i < 8; i++)
        begin
            u_pmp_operator.press(0, 1'b0);
            chk("mode", i % 4, {30'h0, panel_mode_o});
        end
        key(1, 1'b0, 7'h07);
        key(2, 1'b0, 7'h03);
        key(2, 1'b0, 7'h0F);
        key(1, 1'b0, 7'h03);
        key(1, 1'b0, 7'h07);
        pos(4, 5'h10);
        pos(3, 5'h11);
        pos(0, 5'h0D);
        $display("test mode and items done");
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_i);
            pulse_dec_i <= 1'b1;
            pulse_inc_i <= (i == 3);
            @(posedge clk_i);
            pulse_dec_i <= 1'b0;
            pulse_inc_i <= 1'b0;
        end
        rchk("count", 8'h10, 32'hFFFFFFFD);
        key(3, 1'b1, 7'h47);
        pos(4, 5'h12);
        pos(1, 5'h00);
        pos(0, 5'h03);
        key(3, 1'b0, 7'h57);
        pos(0, 5'h00);
        key(3, 1'b0, 7'h67);
        pos(0, 5'h00);
        key(3, 1'b0, 7'h47);
        pos(0, 5'h03);
        key(3, 1'b1, 7'h07);
        pos(0, 5'h0D);
        $display("test pulse paging done");
        wb(1'b1, 8'h04, 32'h00000032);
        wb(1'b1, 8'h08, 32'h0000007B);
        key(1, 1'b0, 7'h0B);
        key(3, 1'b1, 7'h4B);
        pos(1, 5'h05);
        pos(0, 5'h00);
        wb(1'b1, 8'h00, 32'h00000001);
        rchk("ctrl", 8'h00, 32'h1);
        repeat (70) @(posedge clk_i);
        pos(2, 5'h01);
        pos(1, 5'h02);
        pos(0, 5'h03);
        key(3, 1'b1, 7'h0B);
        pos(1, 5'h01);
        pos(0, 5'h00);
        $display("test limit done");
        hall_u_i <= 1'b1;
        hall_w_i <= 1'b1;
        key(1, 1'b0, 7'h0F);
        key(3, 1'b1, 7'h4F);
        pos(0, 5'h14);
        pos(1, 5'h15);
        pos(2, 5'h14);
        key(3, 1'b1, 7'h0F);
        in_term_i <= 8'hA5;
        key(1, 1'b0, 7'h03);
        key(3, 1'b1, 7'h43);
        for (int i = 0; i < 8; i++)
            pos(i, in_term_i[i] ? 5'h15 : 5'h14);
        key(3, 1'b1, 7'h03);
        $display("test hall and inputs done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
